//--- snv_pkg.sv
// Constants and helpers shared by the serial nonvolatile memory slave.
`default_nettype none

package snv_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 8192;
  localparam logic [12:0] ADDR_TOP = 13'h1FFF;
  localparam logic [12:0] ADDR_ZERO = 13'h0000;

  // ==========================================================================
  // Command byte encodings
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_PROTECT_CFG_CMD = 8'h05;
  localparam logic [7:0] WRITE_PROTECT_CFG_CMD = 8'h01;
  localparam logic [7:0] READ_MEM_CMD = 8'h03;
  localparam logic [7:0] WRITE_MEM_CMD = 8'h02;

  // ==========================================================================
  // Protection configuration byte layout and block bases
  localparam int CFG_WPEN_BIT = 7;
  localparam int CFG_BP_HI_BIT = 3;
  localparam int CFG_BP_LO_BIT = 2;
  localparam int CFG_WEL_BIT = 1;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [12:0] PROT_QTR_BASE = 13'h1800;
  localparam logic [12:0] PROT_HALF_BASE = 13'h1000;

  // ==========================================================================
  // Pin synchroniser: bit order and idle values; last bit index of a received byte
  localparam int PIN_W = 5;
  localparam int PIN_SCK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_HOLD_N = 3;
  localparam int PIN_WP_N = 4;
  localparam logic [4:0] PIN_RST_VAL = 5'h1A;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Protected-range check for a write location
  function automatic logic snv_protected(input logic [1:0] bp, input logic [12:0] loc);
    case (bp)
      BP_NONE: snv_protected = 1'b0;
      BP_QUARTER: snv_protected = (loc >= PROT_QTR_BASE);
      BP_HALF: snv_protected = (loc >= PROT_HALF_BASE);
      default: snv_protected = 1'b1;
    endcase
  endfunction : snv_protected

endpackage : snv_pkg

`default_nettype wire

//--- snv_sync.sv
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
`default_nettype none

module snv_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [snv_pkg::PIN_W-1:0] pins_i,
  output logic [snv_pkg::PIN_W-1:0] pins_o
);

  // ==========================================================================
  // Per-pin stages; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < snv_pkg::PIN_W; gi = gi + 1)
    begin : g_pin
      logic meta_r;
      logic stab_r;
      always_ff @(posedge clock_i)
      begin
        if (rst_i)
        begin
          meta_r <= snv_pkg::PIN_RST_VAL[gi];
          stab_r <= snv_pkg::PIN_RST_VAL[gi];
        end
        else
        begin
          meta_r <= pins_i[gi];
          stab_r <= meta_r;
        end
      end
      assign pins_o[gi] = stab_r;
    end
  endgenerate

endmodule : snv_sync

`default_nettype wire

//--- snv_mem.sv
// 8K x 8 array with one shared address and a registered read port.
`timescale 1ns/1ps
`default_nettype none

module snv_mem (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [snv_pkg::ADDR_W-1:0] addr_i,
  input wire logic we_i,
  input wire logic [snv_pkg::DATA_W-1:0] wdata_i,
  output logic [snv_pkg::DATA_W-1:0] rdata_o
);

  logic [snv_pkg::DATA_W-1:0] mem_r [0:snv_pkg::MEM_DEPTH-1];

  // ==========================================================================
  // Array write; the array itself has no reset, like the nonvolatile cells
  always_ff @(posedge clock_i)
  begin
    if (we_i)
      mem_r[addr_i] <= wdata_i;
  end

  // Registered read of the current location
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= mem_r[addr_i];
  end

endmodule : snv_mem

`default_nettype wire

//--- snv_top.sv
// Serial peripheral slave for an 8K x 8 nonvolatile array.
// Function
// [R1] Host sends set-latch command in an earlier frame before any memory write.
// [R2] Write address is two bytes; low 13 bits used, top three dropped.
// [R3] Byte location advances after every data byte while selected.
// [R4] Location wraps from the top address to zero and continues.
// [R5] Data bytes are shifted most significant bit first.
// [R6] Chip select rising ends a write frame.
// [R7] Write reaching a protected block freezes the location, drops further bytes.
// [R8] Each byte is stored as its eighth bit arrives, no page buffer.
// [R9] Write bursts of any length at full serial rate.
// [R10] A partly shifted byte never reaches the array.
// [R11] Host lowers select then sends the read command first.
// [R12] Read address is two bytes; low 13 bits used, top three ignored.
// [R13] Read data shifts out on the clocks right after the address.
// [R14] Serial input is ignored during read data bytes.
// [R15] Chip select rising ends a read and floats the output.
// [R16] Pause input low suspends the frame, keeping bit, location, command.
// [R17] Host changes pause only while serial clock is low.
// [R18] Pause released with clock low resumes exactly where stopped.
// [R19] While paused, clock and select toggles are ignored.
// [R20] Command codes 06,04,05,01,03,02 as defined in the package.
// [R21] Write latch clears at select rise after clear, config write or memory write.
// [R22] Protect bits: none, from 1800h, from 1000h, whole array.
// [R23] Clock mode 0 or 3 taken from serial clock level at select fall.
// [R24] Unknown command: rest of frame ignored, output stays floating.
// [R25] Memory write with the latch clear is ignored entirely.
`timescale 1ns/1ps
`default_nettype none

module snv_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic spi_mode3_o,
  output logic write_latch_flag_o
);

  // ==========================================================================
  // Frame states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CMD = 9'h002,
    ST_ADR_HI = 9'h004,
    ST_ADR_LO = 9'h008,
    ST_WDATA = 9'h010,
    ST_RDATA = 9'h020,
    ST_CFG_RD = 9'h040,
    ST_CFG_WR = 9'h080,
    ST_IGNORE = 9'h100
  } snv_state_type;

  snv_state_type state_r;
  snv_state_type state_nxt;

  logic [snv_pkg::PIN_W-1:0] pins_s;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic paused;
  logic sck_prev_r;
  logic cs_prev_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bit_cnt_r;
  logic [2:0] tx_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte;
  logic byte_done;
  logic is_read_r;
  logic wel_r;
  logic clr_pend_r;
  logic wpen_r;
  logic block_protect_hi;
  logic block_protect_lo;
  logic [12:0] byte_location;
  logic frozen_r;
  logic loc_prot;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [6:0] tx_sh_r;
  logic so_r;
  logic drive_r;
  logic mode3_r;

  // ==========================================================================
  // Pin synchronisers and memory array
  snv_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pins_i({wp_n_i, hold_n_i, si_i, cs_n_i, sck_i}),
    .pins_o(pins_s)
  );

  assign sck_s = pins_s[snv_pkg::PIN_SCK];
  assign cs_n_s = pins_s[snv_pkg::PIN_CS_N];
  assign si_s = pins_s[snv_pkg::PIN_SI];
  assign hold_n_s = pins_s[snv_pkg::PIN_HOLD_N];
  assign wp_n_s = pins_s[snv_pkg::PIN_WP_N];

  snv_mem u_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .addr_i(byte_location),
    .we_i(mem_we),
    .wdata_i(rx_byte),
    .rdata_o(mem_rdata)
  );

  // ==========================================================================
  // Edge detection; history frozen while paused so resume sees no false edge
  assign paused = ~hold_n_s; // [R16]
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sck_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end
    else if (!paused) // [R19]
    begin
      sck_prev_r <= sck_s;
      cs_prev_r <= cs_n_s;
    end
  end

  // Clock edges only count while selected and not paused; select edges count whenever not paused
  assign sck_rise = !paused && !cs_n_s && sck_s && !sck_prev_r; // [R18]
  assign sck_fall = !paused && !cs_n_s && !sck_s && sck_prev_r;
  assign cs_fall = !paused && !cs_n_s && cs_prev_r;
  assign cs_rise = !paused && cs_n_s && !cs_prev_r;
  assign rx_byte = {rx_sh_r, si_s}; // [R5]
  assign byte_done = sck_rise && (bit_cnt_r == snv_pkg::LAST_BIT);

  // Mode capture at select fall
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      mode3_r <= 1'b0;
    else if (cs_fall)
      mode3_r <= sck_s; // [R23]
  end

  // ==========================================================================
  // Receive shifter and bit position; a byte is only used once complete
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end
    else if (cs_fall)
      bit_cnt_r <= 3'h0;
    else if (sck_rise)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= rx_byte[6:0]; // [R5] [R10]
    end
  end

  // ==========================================================================
  // Frame sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_CMD:
      begin
        case (rx_byte) // [R20]
          snv_pkg::READ_MEM_CMD: state_nxt = ST_ADR_HI; // [R11]
          snv_pkg::WRITE_MEM_CMD: state_nxt = wel_r ? ST_ADR_HI : ST_IGNORE; // [R1] [R25]
          snv_pkg::READ_PROTECT_CFG_CMD: state_nxt = ST_CFG_RD;
          snv_pkg::WRITE_PROTECT_CFG_CMD: state_nxt = wel_r ? ST_CFG_WR : ST_IGNORE;
          default: state_nxt = ST_IGNORE; // [R24]
        endcase
      end
      ST_ADR_HI: state_nxt = ST_ADR_LO;
      ST_ADR_LO: state_nxt = is_read_r ? ST_RDATA : ST_WDATA; // [R13]
      ST_CFG_WR: state_nxt = ST_IGNORE;
      default: state_nxt = state_r;
    endcase
  end

  // State register; select rise ends any frame
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else if (cs_rise)
      state_r <= ST_IDLE; // [R6] [R15]
    else if (cs_fall)
      state_r <= ST_CMD;
    else if (byte_done)
      state_r <= state_nxt;
  end

  // Read or write flavour of the address phase
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      is_read_r <= 1'b0;
    else if (byte_done && state_r == ST_CMD)
      is_read_r <= (rx_byte == snv_pkg::READ_MEM_CMD);
  end

  // ==========================================================================
  // Write latch: set by its command, cleared at the select rise that ends
  // a clear, config write or memory write frame
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wel_r <= 1'b0;
      clr_pend_r <= 1'b0;
    end
    else if (cs_fall)
      clr_pend_r <= 1'b0;
    else if (cs_rise && clr_pend_r)
    begin
      wel_r <= 1'b0; // [R21]
      clr_pend_r <= 1'b0;
    end
    else if (byte_done && state_r == ST_CMD)
    begin
      if (rx_byte == snv_pkg::SET_WRITE_LATCH_CMD)
        wel_r <= 1'b1;
      clr_pend_r <= (rx_byte == snv_pkg::CLEAR_WRITE_LATCH_CMD) ||
                    (rx_byte == snv_pkg::WRITE_PROTECT_CFG_CMD) ||
                    (rx_byte == snv_pkg::WRITE_MEM_CMD); // [R21]
    end
  end

  // Protection configuration; the pin only guards it when enabled
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wpen_r <= 1'b0;
      block_protect_hi <= 1'b0;
      block_protect_lo <= 1'b0;
    end
    else if (byte_done && state_r == ST_CFG_WR && wel_r && (!wpen_r || wp_n_s))
    begin
      wpen_r <= rx_byte[snv_pkg::CFG_WPEN_BIT];
      block_protect_hi <= rx_byte[snv_pkg::CFG_BP_HI_BIT];
      block_protect_lo <= rx_byte[snv_pkg::CFG_BP_LO_BIT];
    end
  end

  // ==========================================================================
  // Location counter and array commit
  assign loc_prot = snv_pkg::snv_protected({block_protect_hi, block_protect_lo},
                                           byte_location); // [R22]
  // Store on the eighth rising edge itself; no page buffer, no wait state
  assign mem_we = byte_done && state_r == ST_WDATA && !frozen_r && !loc_prot; // [R8] [R9]

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      frozen_r <= 1'b0;
    else if (cs_fall)
      frozen_r <= 1'b0;
    else if (byte_done && state_r == ST_WDATA && loc_prot)
      frozen_r <= 1'b1; // [R7]
  end

  // Address bytes load the counter; each stored or sent array byte advances it
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      byte_location <= snv_pkg::ADDR_ZERO;
    else if (byte_done && state_r == ST_ADR_HI)
      byte_location[12:8] <= rx_byte[4:0]; // [R2] [R12]
    else if (byte_done && state_r == ST_ADR_LO)
      byte_location[7:0] <= rx_byte;
    else if (mem_we || tx_load && state_r == ST_RDATA)
      byte_location <= byte_location + 13'h0001; // [R3] [R4]
  end

  // ==========================================================================
  // Transmit path: load on the first falling edge of each byte, shift after
  assign tx_load = sck_fall && (state_r == ST_RDATA || state_r == ST_CFG_RD) &&
                   (tx_cnt_r == 3'h0);
  // Config byte reads back with its unused bits as zero
  assign tx_byte = (state_r == ST_RDATA) ? mem_rdata :
                   {wpen_r, 3'h0, block_protect_hi, block_protect_lo, wel_r, 1'b0};

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      tx_cnt_r <= 3'h0;
    else if (cs_fall)
      tx_cnt_r <= 3'h0;
    else if (sck_fall && (state_r == ST_RDATA || state_r == ST_CFG_RD))
      tx_cnt_r <= tx_cnt_r + 3'h1; // [R13]
  end

  // Serial input is never looked at here, so it cannot disturb read data
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      so_r <= 1'b0;
      tx_sh_r <= 7'h00;
    end
    else if (tx_load)
    begin
      so_r <= tx_byte[7]; // [R5] [R14]
      tx_sh_r <= tx_byte[6:0];
    end
    else if (sck_fall && (state_r == ST_RDATA || state_r == ST_CFG_RD))
    begin
      so_r <= tx_sh_r[6];
      tx_sh_r <= {tx_sh_r[5:0], 1'b0};
    end
  end

  // Output driven from first load until select rises; floats while paused
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      drive_r <= 1'b0;
    else if (cs_rise || cs_fall)
      drive_r <= 1'b0; // [R15]
    else if (tx_load)
      drive_r <= 1'b1;
  end

  assign so_o = so_r;
  assign so_oe_n_o = !(drive_r && !paused && !cs_n_s); // [R15] [R16]
  assign spi_mode3_o = mode3_r;
  assign write_latch_flag_o = wel_r;

  // ==========================================================================
  // Checks
  a_mode_capture: assert property (@(posedge clock_i) disable iff (rst_i) // [R23]
    cs_fall |=> mode3_r == $past(sck_s))
    else $error("mode not taken from clock level at select fall");

  a_latch_clear: assert property (@(posedge clock_i) disable iff (rst_i) // [R21]
    (cs_rise && clr_pend_r) |=> !wel_r)
    else $error("write latch not cleared at frame end");

  a_no_latch_write: assert property (@(posedge clock_i) disable iff (rst_i) // [R25]
    mem_we |-> wel_r)
    else $error("array written without write latch");

  a_protect_block: assert property (@(posedge clock_i) disable iff (rst_i) // [R7]
    (byte_done && state_r == ST_WDATA && loc_prot) |=> frozen_r && $stable(byte_location))
    else $error("protected location did not freeze counter");

  a_commit_bit8: assert property (@(posedge clock_i) disable iff (rst_i) // [R8]
    mem_we |-> sck_rise && bit_cnt_r == 3'h7)
    else $error("array written away from eighth bit");

  a_loc_advance: assert property (@(posedge clock_i) disable iff (rst_i) // [R3]
    (mem_we && byte_location != snv_pkg::ADDR_TOP)
      |=> byte_location == $past(byte_location) + 13'h0001)
    else $error("location did not advance after stored byte");

  a_loc_wrap: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
    (tx_load && state_r == ST_RDATA && byte_location == snv_pkg::ADDR_TOP)
      |=> byte_location == snv_pkg::ADDR_ZERO)
    else $error("location did not wrap to zero");

  a_msb_out: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
    (tx_load && state_r == ST_RDATA) |=> so_r == $past(mem_rdata[7]) && drive_r)
    else $error("read byte not started with its top bit");

  a_pause_hold: assert property (@(posedge clock_i) disable iff (rst_i) // [R19]
    (paused && $past(paused)) |-> $stable(state_r) && $stable(bit_cnt_r) &&
      $stable(byte_location) && $stable(tx_cnt_r) && so_oe_n_o)
    else $error("paused frame changed or output driven");

  a_end_float: assert property (@(posedge clock_i) disable iff (rst_i) // [R15]
    cs_rise |=> so_oe_n_o && state_r == ST_IDLE)
    else $error("output still driven after select rise");

  a_ignore_float: assert property (@(posedge clock_i) disable iff (rst_i) // [R24]
    state_r == ST_IGNORE |-> so_oe_n_o)
    else $error("output driven in ignored frame");

endmodule : snv_top

`default_nettype wire

//--- snv_master.sv
// Bus master model that drives the serial pins of the memory slave.
`timescale 1ns/1ps
`default_nettype none

module snv_master (
  input wire logic clock_i,
  input wire logic so_i,
  input wire logic so_oe_n_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  // ==========================================================================
  // Pin state; a 6-clock half period leaves margin over the 4-clock minimum
  localparam int HALF = 6;
  logic mode3_r = 1'b0;
  logic oe_seen_r = 1'b0;

  // Idle pins at time zero; non-blocking like every later drive of these pins
  initial
  begin
    sck_o <= 1'b0;
    cs_n_o <= 1'b1;
    si_o <= 1'b0;
    hold_n_o <= 1'b1;
  end

  task automatic clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask : clk

  // Select with the clock idling at the level that picks the mode
  task automatic open(input logic m3);
    mode3_r = m3;
    oe_seen_r = 1'b0;
    @(posedge clock_i);
    sck_o <= m3;
    clk(HALF);
    cs_n_o <= 1'b0;
    clk(HALF);
  endtask : open

  // Deselect; the released data line shows the inverse of its last bit
  task automatic close();
    sck_o <= mode3_r;
    clk(HALF);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    clk(2 * HALF);
    @(negedge clock_i);
  endtask : close

  // Pause with the clock low; clock and select wiggle while paused
  task automatic pause();
    hold_n_o <= 1'b0;
    clk(HALF);
    sck_o <= 1'b1;
    cs_n_o <= 1'b1;
    clk(HALF);
    sck_o <= 1'b0;
    cs_n_o <= 1'b0;
    clk(HALF);
    hold_n_o <= 1'b1;
    clk(HALF);
  endtask : pause

  // Shift bits MSB first, sampling the reply where it has settled
  task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nbits; i--)
    begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      clk(HALF);
      if (i == hold_at)
        pause();
      @(negedge clock_i);
      // A floating reply line reads as the inverse of its last value, so an
      // undriven output can never pass for good data
      rx[i] = so_oe_n_i ? ~so_i : so_i;
      oe_seen_r = oe_seen_r | ~so_oe_n_i;
      @(posedge clock_i);
      sck_o <= 1'b1;
      clk(HALF);
    end
  endtask : xfer
endmodule : snv_master

`default_nettype wire

//--- snv_top_tb.sv
// Self-checking bench for the serial memory slave.
`timescale 1ns/1ps
`default_nettype none

module snv_top_tb;
  // ==========================================================================
  // Clock, reset, pins and bookkeeping
  logic clock_i;
  logic rst_i;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n = 1'b1;
  logic so;
  logic so_oe_n;
  logic mode3;
  logic latch;
  int err_count = 0;
  int cmp_count = 0;
  logic [1:0] bp_cur = 2'h0;
  logic [7:0] shadow [0:8191];
  logic [7:0] rx;

  // Free-running 100 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  snv_top dut (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n),
    .spi_mode3_o(mode3), .write_latch_flag_o(latch));

  snv_master m (.clock_i(clock_i), .so_i(so), .so_oe_n_i(so_oe_n), .sck_o(sck),
    .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // Bench's own view of which locations the protect bits guard
  function automatic logic is_prot(input logic [1:0] bp, input logic [12:0] loc);
    return (bp == 2'h3) || (bp == 2'h2 && loc >= 13'h1000) || (bp == 2'h1 && loc >= 13'h1800);
  endfunction : is_prot

  task automatic cmd1(input logic [7:0] op);
    m.open(1'b0);
    m.xfer(op, 8, -1, rx);
    m.close();
  endtask : cmd1

  // Enabled config write, then read the config byte back
  task automatic cfg(input logic [1:0] bp);
    cmd1(snv_pkg::SET_WRITE_LATCH_CMD);
    m.open(1'b0);
    m.xfer(snv_pkg::WRITE_PROTECT_CFG_CMD, 8, -1, rx);
    m.xfer({4'h0, bp, 2'h0}, 8, -1, rx);
    m.close();
    bp_cur = bp;
    m.open(1'b0);
    m.xfer(snv_pkg::READ_PROTECT_CFG_CMD, 8, -1, rx);
    m.xfer(8'h00, 8, -1, rx);
    m.close();
    chk(rx, {4'h0, bp, 2'h0});
  endtask : cfg

  // Write frame; the shadow follows what the slave should keep
  task automatic wr(input logic [12:0] a, input logic [7:0] d[$], input logic en,
                    input int hold_at, input int tail);
    logic [12:0] loc;
    logic stop;
    loc = a;
    stop = 1'b0;
    if (en)
      cmd1(snv_pkg::SET_WRITE_LATCH_CMD);
    m.open(1'b0);
    m.xfer(snv_pkg::WRITE_MEM_CMD, 8, -1, rx);
    m.xfer({3'h7, a[12:8]}, 8, -1, rx);
    m.xfer(a[7:0], 8, -1, rx);
    foreach (d[i])
    begin
      m.xfer(d[i], (i == d.size() - 1) ? tail : 8, (i == 0) ? hold_at : -1, rx);
      stop = stop | ~en | is_prot(bp_cur, loc) | (i == d.size() - 1 && tail < 8);
      if (!stop)
      begin
        shadow[loc] = d[i];
        loc = loc + 13'h0001;
      end
    end
    m.close();
    chk({7'h00, latch}, 8'h00);
  endtask : wr

  // Read burst; junk on the data input must not disturb the reply
  task automatic rd(input logic [12:0] a, input int n, input logic m3, input int hold_at);
    logic [12:0] loc;
    loc = a;
    m.open(m3);
    m.xfer(snv_pkg::READ_MEM_CMD, 8, -1, rx);
    m.xfer({3'h5, a[12:8]}, 8, -1, rx);
    m.xfer(a[7:0], 8, -1, rx);
    for (int k = 0; k < n; k++)
    begin
      m.xfer(8'h5A ^ k[7:0], 8, (k == 0) ? hold_at : -1, rx);
      chk(rx, shadow[loc]);
      loc = loc + 13'h0001;
    end
    chk({7'h00, m.oe_seen_r}, 8'h01);
    m.close();
    chk({7'h00, so_oe_n}, 8'h01);
    chk({7'h00, mode3}, {7'h00, m3});
  endtask : rd

  task automatic t_burst();
    logic [7:0] d[$];
    for (int k = 0; k < 20; k++)
      d.push_back(8'hA5 + 8'(k * 37));
    wr(13'h1FF6, d, 1'b1, -1, 8);
    rd(13'h1FF6, 20, 1'b0, -1);
    $display("burst test done");
  endtask : t_burst

  task automatic t_guard();
    wr(13'h0040, '{8'h11, 8'h22}, 1'b1, -1, 8);
    wr(13'h0040, '{8'hEE}, 1'b0, -1, 8);
    cmd1(snv_pkg::SET_WRITE_LATCH_CMD);
    chk({7'h00, latch}, 8'h01);
    cmd1(snv_pkg::CLEAR_WRITE_LATCH_CMD);
    chk({7'h00, latch}, 8'h00);
    wr(13'h0041, '{8'hDD}, 1'b0, -1, 8);
    rd(13'h0040, 2, 1'b0, -1);
    $display("latch test done");
  endtask : t_guard

  task automatic t_protect();
    logic [12:0] locs [3];
    locs = '{13'h0FFF, 13'h17FF, 13'h1800};
    for (int j = 0; j < 3; j++)
      wr(locs[j], '{8'h30 + 8'(j)}, 1'b1, -1, 8);
    for (int b = 1; b < 4; b++)
    begin
      cfg(2'(b));
      for (int j = 0; j < 3; j++)
      begin
        wr(locs[j], '{8'(16 * b + j)}, 1'b1, -1, 8);
        rd(locs[j], 1, 1'b0, -1);
      end
    end
    cfg(2'h1);
    wr(13'h17FE, '{8'hC1, 8'hC2, 8'hC3, 8'hC4}, 1'b1, -1, 8);
    rd(13'h17FE, 3, 1'b0, -1);
    cfg(2'h0);
    $display("protect test done");
  endtask : t_protect

  task automatic t_pause();
    wr(13'h0200, '{8'h3C, 8'h96}, 1'b1, 3, 8);
    rd(13'h0200, 2, 1'b0, 4);
    rd(13'h0200, 2, 1'b1, -1);
    $display("pause and mode test done");
  endtask : t_pause

  task automatic t_misc();
    wr(13'h0300, '{8'h5A, 8'h77}, 1'b1, -1, 8);
    wr(13'h0300, '{8'h12, 8'hFF}, 1'b1, -1, 4);
    rd(13'h0300, 2, 1'b0, -1);
    m.open(1'b0);
    m.xfer(8'hFF, 8, -1, rx);
    repeat (3) m.xfer(8'h00, 8, -1, rx);
    chk({7'h00, m.oe_seen_r}, 8'h00);
    m.close();
    $display("partial and unknown command test done");
  endtask : t_misc

  // Main sequence: reset, idle checks, scenarios
  initial
  begin
    rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk({6'h00, so_oe_n, latch}, 8'h02);
    t_burst();
    t_guard();
    t_protect();
    t_pause();
    t_misc();
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge clock_i);
    err_count++;
    $display("[ERR] %0t: run did not finish", $time);
    final_report();
  end
endmodule : snv_top_tb

`default_nettype wire
